// ---- cspr_reporter.sv ----
// charger status lamps and one-wire pulse status reporter
`timescale 1ns/10ps
`default_nettype none
`include "cspr_defines.svh"
module cspr_reporter (
    input  wire logic                        clk_sys,
    input  wire logic                        srst,
    input  wire cspr_pkg::cspr_charge_state_t charge_state,
    input  wire logic                        status_line_in,
    output logic                             status_line_out,
    output logic                             status_line_oe,
    output logic                             charge_lamp_first_out,
    output logic                             charge_lamp_first_oe,
    output logic                             charge_lamp_second_out,
    output logic                             charge_lamp_second_oe,
    output logic                             report_busy
);
    import cspr_pkg::*;

    // ----------------------------------------
    // lamp decode
    // ----------------------------------------
    logic                   flash_phase;
    logic [`CSPR_CNT_W-1:0] flash_cnt;
    wire  st_fault   = (charge_state == CSPR_ST_OT_DIE) || (charge_state == CSPR_ST_BAT_TEMP)
                     || (charge_state == CSPR_ST_OVP) || (charge_state == CSPR_ST_PRE_WDT)
                     || (charge_state == CSPR_ST_CC_WDT) || (charge_state == CSPR_ST_CV_WDT);
    wire  st_chg     = (charge_state == CSPR_ST_PRE) || (charge_state == CSPR_ST_CC_TLOOP)
                     || (charge_state == CSPR_ST_CC) || (charge_state == CSPR_ST_CV);
    wire  st_done    = (charge_state == CSPR_ST_DONE);
    wire  st_nobat   = (charge_state == CSPR_ST_NO_BAT);
    wire  next_lamp1 = st_fault || st_chg || (st_nobat && flash_phase);
    wire  next_lamp2 = st_fault || st_done || (st_nobat && flash_phase);
    wire  flash_wrap = (flash_cnt == `CSPR_CNT_W'(`CSPR_FLASH_HALF_CYC - 1));

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            flash_cnt   <= '0;
            flash_phase <= 1'b0;
        end else begin
            flash_cnt   <= flash_wrap ? '0 : flash_cnt + 1'b1;
            flash_phase <= flash_wrap ? ~flash_phase : flash_phase;
        end
    end

    logic lamp1_on;
    logic lamp2_on;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lamp1_on <= 1'b0;
            lamp2_on <= 1'b0;
        end else begin
            lamp1_on <= next_lamp1;
            lamp2_on <= next_lamp2;
        end
    end

    // open drain: drive low only when lit
    assign charge_lamp_first_out  = 1'b0;
    assign charge_lamp_first_oe   = lamp1_on;
    assign charge_lamp_second_out = 1'b0;
    assign charge_lamp_second_oe  = lamp2_on;

    // ----------------------------------------
    // status line input
    // ----------------------------------------
    logic line_sync;
    logic line_prev;
    cspr_sync u_line_sync (
        .clk_sys  (clk_sys),
        .srst     (srst),
        .pin_in   (status_line_in),
        .pin_sync (line_sync)
    );

    // ----------------------------------------
    // status count lookup
    // ----------------------------------------
    logic [4:0] lookup_count;
    always_comb begin
        unique case (charge_state)
            CSPR_ST_OT_DIE:   lookup_count = `CSPR_CNT_OT_DIE;
            CSPR_ST_BAT_TEMP: lookup_count = `CSPR_CNT_BAT_TEMP;
            CSPR_ST_OVP:      lookup_count = `CSPR_CNT_OVP;
            CSPR_ST_PRE_WDT:  lookup_count = `CSPR_CNT_PRE_WDT;
            CSPR_ST_PRE:      lookup_count = `CSPR_CNT_PRE;
            CSPR_ST_CC_WDT:   lookup_count = `CSPR_CNT_CC_WDT;
            CSPR_ST_CC_TLOOP: lookup_count = `CSPR_CNT_CC_TLOOP;
            CSPR_ST_CC:       lookup_count = `CSPR_CNT_CC;
            CSPR_ST_CV_WDT:   lookup_count = `CSPR_CNT_CV_WDT;
            CSPR_ST_CV:       lookup_count = `CSPR_CNT_CV;
            CSPR_ST_DONE:     lookup_count = `CSPR_CNT_DONE;
            default:          lookup_count = `CSPR_CNT_ERROR;
        endcase
    end

    // ----------------------------------------
    // request strobe and reply train
    // ----------------------------------------
    cspr_link_state_t       lk_state;
    logic [`CSPR_CNT_W-1:0] low_len;
    logic [`CSPR_CNT_W-1:0] timer;
    logic [4:0]             rpt_count;
    logic [4:0]             sent;

    wire line_rise  = line_sync && !line_prev;
    wire strobe_ok  = (low_len >= `CSPR_CNT_W'(`CSPR_REQ_MIN_CYC))
                    && (low_len < `CSPR_CNT_W'(`CSPR_REQ_MAX_CYC));
    wire take_req   = (lk_state == CSPR_LK_IDLE) && line_rise && strobe_ok;
    wire wait_done  = (timer == `CSPR_CNT_W'(`CSPR_RPT_DELAY_CYC - 1));
    wire low_done   = (timer == `CSPR_CNT_W'(`CSPR_PULSE_LOW_CYC - 1));
    wire high_done  = (timer == `CSPR_CNT_W'(`CSPR_PULSE_PERIOD_CYC - `CSPR_PULSE_LOW_CYC - 1));
    wire last_pulse = (sent == rpt_count);
    wire low_sat    = (low_len == {`CSPR_CNT_W{1'b1}});

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            line_prev <= 1'b1;
            low_len   <= '0;
        end else begin
            line_prev <= line_sync;
            if (line_rise || lk_state != CSPR_LK_IDLE)
                low_len <= '0;
            else if (!line_sync && !low_sat)
                low_len <= low_len + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lk_state  <= CSPR_LK_IDLE;
            timer     <= '0;
            rpt_count <= '0;
            sent      <= '0;
        end else begin
            unique case (lk_state)
                CSPR_LK_IDLE: if (take_req) begin
                    rpt_count <= lookup_count;
                    sent      <= '0;
                    timer     <= '0;
                    lk_state  <= CSPR_LK_WAIT;
                end
                CSPR_LK_WAIT: begin
                    timer <= wait_done ? '0 : timer + 1'b1;
                    if (wait_done) begin
                        sent     <= sent + 1'b1;
                        lk_state <= CSPR_LK_LOW;
                    end
                end
                CSPR_LK_LOW: begin
                    timer <= low_done ? '0 : timer + 1'b1;
                    if (low_done)
                        lk_state <= CSPR_LK_HIGH;
                end
                CSPR_LK_HIGH: begin
                    timer <= high_done ? '0 : timer + 1'b1;
                    if (high_done && last_pulse)
                        lk_state <= CSPR_LK_IDLE;
                    else if (high_done) begin
                        sent     <= sent + 1'b1;
                        lk_state <= CSPR_LK_LOW;
                    end
                end
            endcase
        end
    end

    // line only ever pulled low
    assign status_line_out = 1'b0;
    assign status_line_oe  = (lk_state == CSPR_LK_LOW);
    assign report_busy     = (lk_state != CSPR_LK_IDLE);
endmodule : cspr_reporter
`default_nettype wire

// ---- cspr_defines.svh ----
// constants for the charger status pulse reporter
`ifndef CSPR_DEFINES_SVH
`define CSPR_DEFINES_SVH

`define CSPR_CLK_PERIOD_NS      20
`define CSPR_REQ_MIN_NS         200
`define CSPR_REQ_MIN_CYC        ((`CSPR_REQ_MIN_NS + `CSPR_CLK_PERIOD_NS - 1) / `CSPR_CLK_PERIOD_NS)
`define CSPR_REQ_MAX_US         500
`define CSPR_REQ_MAX_CYC        ((`CSPR_REQ_MAX_US * 1000) / `CSPR_CLK_PERIOD_NS)
`define CSPR_RPT_DELAY_US       100
`define CSPR_RPT_DELAY_CYC      ((`CSPR_RPT_DELAY_US * 1000) / `CSPR_CLK_PERIOD_NS)
`define CSPR_PULSE_PERIOD_US    100
`define CSPR_PULSE_PERIOD_CYC   ((`CSPR_PULSE_PERIOD_US * 1000) / `CSPR_CLK_PERIOD_NS)
`define CSPR_PULSE_LOW_CYC      (`CSPR_PULSE_PERIOD_CYC / 2)
`define CSPR_FLASH_HALF_MS      250
`define CSPR_FLASH_HALF_CYC     ((`CSPR_FLASH_HALF_MS * 1000000) / `CSPR_CLK_PERIOD_NS)
`define CSPR_CNT_W              24

`define CSPR_CNT_OT_DIE         5'h01
`define CSPR_CNT_BAT_TEMP       5'h02
`define CSPR_CNT_OVP            5'h03
`define CSPR_CNT_PRE_WDT        5'h05
`define CSPR_CNT_PRE            5'h06
`define CSPR_CNT_CC_WDT         5'h07
`define CSPR_CNT_CC_TLOOP       5'h08
`define CSPR_CNT_CC             5'h09
`define CSPR_CNT_CV_WDT         5'h0a
`define CSPR_CNT_CV             5'h0b
`define CSPR_CNT_DONE           5'h0c
`define CSPR_CNT_ERROR          5'h17

`endif

// ---- cspr_pkg.sv ----
// types for the charger status pulse reporter
package cspr_pkg;
    typedef enum logic [3:0] {
        CSPR_ST_OFF       = 4'h0,
        CSPR_ST_NO_BAT    = 4'h1,
        CSPR_ST_OT_DIE    = 4'h2,
        CSPR_ST_BAT_TEMP  = 4'h3,
        CSPR_ST_OVP       = 4'h4,
        CSPR_ST_PRE_WDT   = 4'h5,
        CSPR_ST_PRE       = 4'h6,
        CSPR_ST_CC_WDT    = 4'h7,
        CSPR_ST_CC_TLOOP  = 4'h8,
        CSPR_ST_CC        = 4'h9,
        CSPR_ST_CV_WDT    = 4'ha,
        CSPR_ST_CV        = 4'hb,
        CSPR_ST_DONE      = 4'hc
    } cspr_charge_state_t;

    typedef enum logic [1:0] {
        CSPR_LK_IDLE  = 2'h0,
        CSPR_LK_WAIT  = 2'h1,
        CSPR_LK_LOW   = 2'h2,
        CSPR_LK_HIGH  = 2'h3
    } cspr_link_state_t;
endpackage : cspr_pkg

// ---- cspr_sync.sv ----
// two-flop synchroniser for one pin
`timescale 1ns/10ps
`default_nettype none
module cspr_sync (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic pin_in,
    output logic      pin_sync
);
    logic stage1;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            stage1   <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            stage1   <= pin_in;
            pin_sync <= stage1;
        end
    end
endmodule : cspr_sync
`default_nettype wire

// ---- cspr_reporter_monitor.sv ----
// port checker for the charger status pulse reporter
`timescale 1ns/10ps
`default_nettype none
module cspr_reporter_monitor
    import cspr_pkg::*;
(
    input wire logic                         clk_sys,
    input wire logic                         srst,
    input wire cspr_pkg::cspr_charge_state_t charge_state,
    input wire logic                         status_line_out,
    input wire logic                         status_line_oe,
    input wire logic                         charge_lamp_first_out,
    input wire logic                         charge_lamp_first_oe,
    input wire logic                         charge_lamp_second_out,
    input wire logic                         charge_lamp_second_oe,
    input wire logic                         report_busy
);
    logic        oe_q;
    logic [11:0] run_cnt;
    logic [17:0] busy_cnt;
    always_ff @(posedge clk_sys) begin
        oe_q     <= status_line_oe;
        run_cnt  <= (srst || status_line_oe != oe_q) ? 12'h000 : run_cnt + 12'h001;
        busy_cnt <= (srst || !report_busy) ? 18'h00000 : busy_cnt + 18'h00001;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    drain_low_a: assert property (!(status_line_out | charge_lamp_first_out | charge_lamp_second_out))
        else $error("open drain data not low");
    idle_release_a: assert property (!report_busy |-> !status_line_oe)
        else $error("line pulled while idle");
    lamp_charge_a: assert property (charge_state == CSPR_ST_CC |=> charge_lamp_first_oe && !charge_lamp_second_oe)
        else $error("charging lamps wrong");
    lamp_done_a: assert property (charge_state == CSPR_ST_DONE |=> !charge_lamp_first_oe && charge_lamp_second_oe)
        else $error("done lamps wrong");
    lamp_fault_a: assert property (charge_state == CSPR_ST_OVP |=> charge_lamp_first_oe && charge_lamp_second_oe)
        else $error("fault lamps wrong");
    lamp_off_a: assert property (charge_state == CSPR_ST_OFF |=> !charge_lamp_first_oe && !charge_lamp_second_oe)
        else $error("off lamps wrong");
    flash_pair_a: assert property (charge_state == CSPR_ST_NO_BAT |=> charge_lamp_first_oe == charge_lamp_second_oe)
        else $error("flash lamps apart");
    pulse_width_a: assert property ($fell(status_line_oe) |-> run_cnt == 12'd2499)
        else $error("reply pulse width wrong");
    reply_delay_a: assert property ($rose(status_line_oe) |-> busy_cnt >= 18'd4998 && (busy_cnt <= 18'd5002 || busy_cnt >= 18'd9998))
        else $error("reply start delay wrong");
endmodule : cspr_reporter_monitor
bind cspr_reporter cspr_reporter_monitor u_cspr_reporter_monitor (.clk_sys, .srst, .charge_state,
    .status_line_out, .status_line_oe, .charge_lamp_first_out, .charge_lamp_first_oe,
    .charge_lamp_second_out, .charge_lamp_second_oe, .report_busy);
`default_nettype wire

// ---- cspr_host_model.sv ----
// host side of the one-wire status line
`timescale 1ns/10ps
`default_nettype none
module cspr_host_model (
    input wire logic        clk_sys,
    input wire logic        go,
    input wire logic [15:0] low_len,
    input wire logic        status_line,
    output logic            host_oe,
    output logic [7:0]      pulse_cnt
);
    logic [15:0] left = 16'h0000;
    logic        line_q = 1'b1;
    assign host_oe = (left != 16'h0000);
    initial pulse_cnt = 8'h00;
    always @(posedge clk_sys) begin
        line_q <= status_line;
        if (line_q && !status_line && !host_oe)
            pulse_cnt <= pulse_cnt + 8'h01;
        if (left != 16'h0000)
            left <= left - 16'h0001;
        if (go) begin
            left      <= low_len;
            pulse_cnt <= 8'h00;
        end
    end
endmodule : cspr_host_model
`default_nettype wire

// ---- tb_charger_status_pulse_reporter.sv ----
// testbench for the charger status pulse reporter
`timescale 1ns/10ps
`default_nettype none
`define TB_CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t value mismatch", $time); end end
module tb_charger_status_pulse_reporter;
    import cspr_pkg::*;
    logic               clk_sys = 1'b0;
    logic               srst = 1'b1;
    logic               go = 1'b0;
    logic [15:0]        low_len = 16'h0014;
    cspr_charge_state_t charge_state = CSPR_ST_OFF;
    wire logic          host_oe, line_out, line_oe, l1_out, l1_oe, l2_out, l2_oe, report_busy;
    wire logic [7:0]    pulse_cnt;
    wire logic          status_line = ~(host_oe | line_oe);
    int                 bad_count = 0;
    int                 checks = 0;
    always #10 clk_sys = ~clk_sys;
    cspr_reporter u_cspr_reporter (.clk_sys(clk_sys), .srst(srst), .charge_state(charge_state),
        .status_line_in(status_line), .status_line_out(line_out), .status_line_oe(line_oe),
        .charge_lamp_first_out(l1_out), .charge_lamp_first_oe(l1_oe),
        .charge_lamp_second_out(l2_out), .charge_lamp_second_oe(l2_oe), .report_busy(report_busy));
    cspr_host_model u_cspr_host_model (.clk_sys(clk_sys), .go(go), .low_len(low_len),
        .status_line(status_line), .host_oe(host_oe), .pulse_cnt(pulse_cnt));
    task finish_test;
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    task t_lamps;
        cspr_charge_state_t ls [9] = '{CSPR_ST_OFF, CSPR_ST_PRE, CSPR_ST_CC_TLOOP, CSPR_ST_CV,
            CSPR_ST_DONE, CSPR_ST_OT_DIE, CSPR_ST_BAT_TEMP, CSPR_ST_OVP, CSPR_ST_CC_WDT};
        logic [1:0] le [9] = '{2'h0, 2'h2, 2'h2, 2'h2, 2'h1, 2'h3, 2'h3, 2'h3, 2'h3};
        for (int i = 0; i < 9; i++) begin
            charge_state <= ls[i];
            repeat (2) @(posedge clk_sys);
            `TB_CHK({l1_oe, l2_oe}, le[i])
        end
        charge_state <= CSPR_ST_NO_BAT;
        repeat (4) @(posedge clk_sys);
        `TB_CHK(l1_oe, l2_oe)
        $display("test lamps done");
    endtask : t_lamps
    task t_short;
        int k;
        low_len <= 16'h0005;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        for (k = 0; k < 100 && report_busy !== 1'b1; k++)
            @(posedge clk_sys);
        `TB_CHK(report_busy, 1'b0)
        low_len <= 16'h0014;
        $display("test short strobe done");
    endtask : t_short
    task t_long;
        int k;
        low_len <= 16'h6400;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        for (k = 0; k < 26000 && host_oe !== 1'b0; k++)
            @(posedge clk_sys);
        for (k = 0; k < 100 && report_busy !== 1'b1; k++)
            @(posedge clk_sys);
        `TB_CHK(report_busy, 1'b0)
        low_len <= 16'h0014;
        $display("test long strobe done");
    endtask : t_long
    task t_report(input cspr_charge_state_t st, input logic [7:0] n);
        int k;
        charge_state <= st;
        @(posedge clk_sys);
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        for (k = 0; k < 100 && report_busy !== 1'b1; k++)
            @(posedge clk_sys);
        `TB_CHK(report_busy, 1'b1)
        charge_state <= CSPR_ST_DONE;
        for (k = 0; k < 80000 && report_busy !== 1'b0; k++)
            @(posedge clk_sys);
        if (k >= 80000) begin
            bad_count++;
            $display("[ERR] %0t reply never ended", $time);
            finish_test();
        end
        `TB_CHK(pulse_cnt, n)
        $display("test report %0d done", n);
    endtask : t_report
    initial begin
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        t_lamps();
        t_short();
        t_long();
        t_report(CSPR_ST_OT_DIE, 8'h01);
        t_report(CSPR_ST_OVP, 8'h03);
        t_report(CSPR_ST_CC_WDT, 8'h07);
        finish_test();
    end
endmodule : tb_charger_status_pulse_reporter
`default_nettype wire
